//--- shared/bpsl_pkg.sv
// Constants and types for the bridge parity status block
`default_nettype none
package bpsl_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_MASK     = 8'h04;
    localparam logic [7:0] ADDR_CONTROL  = 8'h08;
    localparam logic [7:0] ADDR_LAST_EVT = 8'h0C;
    // Status and mask bit positions
    localparam int BIT_PRI_DET  = 0;
    localparam int BIT_SEC_DET  = 1;
    localparam int BIT_PRI_MDPE = 2;
    localparam int BIT_SEC_MDPE = 3;
    localparam int NUM_STATUS   = 4;
    // Control bit positions
    localparam int BIT_PRI_PER  = 0;
    localparam int BIT_SEC_PER  = 1;
    // Reset values
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET   = 4'h0;
    localparam logic [1:0] CTRL_RESET   = 2'h0;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef enum logic [1:0] {
        BPSL_READ       = 2'h0,
        BPSL_POSTED_WR  = 2'h1,
        BPSL_DELAYED_WR = 2'h2
    } bpsl_txn_e;
endpackage : bpsl_pkg
`default_nettype wire

//--- core/bpsl_decode.sv
// Decoder from one parity event to the four status-bit set strobes
`default_nettype none
module bpsl_decode
    import bpsl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       evt_valid,
    input  wire logic [1:0] evt_type,
    input  wire logic       evt_upstream,
    input  wire logic       evt_on_secondary,
    input  wire logic       evt_perr_sampled,
    input  wire logic       evt_parity_bad,
    input  wire logic       pri_master,
    input  wire logic       sec_master,
    input  wire logic       pri_per_en,
    input  wire logic       sec_per_en,
    output logic [3:0]      set_strobe
);
    // A defined transaction type; any other encoding sets nothing
    wire       known_type = (evt_type == BPSL_READ)
                         || (evt_type == BPSL_POSTED_WR)
                         || (evt_type == BPSL_DELAYED_WR);
    wire       is_read    = (evt_type == BPSL_READ);
    wire       on_pri     = evt_valid && known_type && !evt_on_secondary;
    wire       on_sec     = evt_valid && known_type && evt_on_secondary;
    wire       seen       = evt_perr_sampled || evt_parity_bad;
    // Target-side detection: upstream read or downstream write on primary
    wire       pri_det    = on_pri && evt_parity_bad
                         && (is_read == evt_upstream);            // RL1 RL2
    wire       sec_det    = on_sec && evt_parity_bad
                         && (is_read != evt_upstream);            // RL3 RL4
    wire       pri_mdpe   = on_pri && evt_upstream && pri_master
                         && pri_per_en && seen;          // RL5 RL6 RL7 RL8
    wire       sec_mdpe   = on_sec && !evt_upstream && sec_master
                         && sec_per_en && seen;      // RL9 RL10 RL11 RL12
    logic [3:0] next_set_strobe;

    assign next_set_strobe = {sec_mdpe, pri_mdpe, sec_det, pri_det};

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            set_strobe <= STATUS_RESET;
        end else begin
            set_strobe <= next_set_strobe;
        end
    end
endmodule : bpsl_decode
`default_nettype wire

//--- core/bpsl_status.sv
// Parity status bits, AHB-Lite register slave and interrupt
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`default_nettype none
// What this block does
// (RL1) Primary detected bit sets on primary parity error, enables ignored.
// (RL2) Primary detected: upstream read, downstream posted or delayed write.
// (RL3) Secondary detected bit sets on secondary error, enables ignored.
// (RL4) Secondary detected: downstream read, upstream posted/delayed write.
// (RL5) Primary master parity bit only while mastering the primary bus.
// (RL6) Primary master parity bit needs primary response enable set.
// (RL7) Primary master bit sets on sampled error pin or own detection.
// (RL8) Primary master bit only for upstream cases with primary error.
// (RL9) Secondary master parity bit only while mastering secondary bus.
// (RL10) Secondary master bit needs secondary response enable set.
// (RL11) Secondary master bit sets on sampled error pin or own detection.
// (RL12) Secondary master bit only for downstream cases, secondary error.
// (RL13) Each status bit stays set until software writes one to it.
module bpsl_status
    import bpsl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Parity event from the bus interfaces
    input  wire logic        evt_valid,
    input  wire logic [1:0]  evt_type,
    input  wire logic        evt_upstream,
    input  wire logic        evt_on_secondary,
    input  wire logic        evt_parity_bad,
    input  wire logic        primary_parity_err_n,
    input  wire logic        secondary_parity_err_n,
    input  wire logic        pri_master,
    input  wire logic        sec_master,
    // Status out
    output logic [3:0]       status,
    output logic             pri_per_en,
    output logic             sec_per_en,
    output logic             irq
);
    logic [3:0]  mask;
    logic [3:0]  set_strobe;
    logic [3:0]  last_evt;
    logic        wr_pend;
    logic [7:0]  wr_addr;

    // Sampled error pin counts only on the bus where the event is seen
    wire perr_sampled = evt_on_secondary ? !secondary_parity_err_n
                                         : !primary_parity_err_n;

    bpsl_decode u_decode (
        .clk_sys          (clk_sys),
        .reset            (reset),
        .evt_valid        (evt_valid),
        .evt_type         (evt_type),
        .evt_upstream     (evt_upstream),
        .evt_on_secondary (evt_on_secondary),
        .evt_perr_sampled (perr_sampled),
        .evt_parity_bad   (evt_parity_bad),
        .pri_master       (pri_master),
        .sec_master       (sec_master),
        .pri_per_en       (pri_per_en),
        .sec_per_en       (sec_per_en),
        .set_strobe       (set_strobe)
    );

    // Address phase decode
    wire        trans_ok  = (htrans == HTRANS_NONSEQ)
                         || (htrans == HTRANS_SEQ);
    wire        addr_take = hsel && hready && trans_ok;
    wire        wr_take   = addr_take && hwrite;
    wire        rd_take   = addr_take && !hwrite;
    wire        wr_status = wr_pend && (wr_addr == ADDR_STATUS);
    wire        wr_mask   = wr_pend && (wr_addr == ADDR_MASK);
    wire        wr_ctrl   = wr_pend && (wr_addr == ADDR_CONTROL);
    // Set wins over the write-one clear in the same cycle
    wire [3:0]  clr_bits  = wr_status ? hwdata[3:0] : 4'h0;
    wire [3:0]  next_status = (status & ~clr_bits) | set_strobe;   // RL13
    wire        next_irq  = |(next_status & mask);

    function automatic logic [31:0] read_mux(input logic [7:0] a,
                                             input logic [3:0] st,
                                             input logic [3:0] mk,
                                             input logic       pe,
                                             input logic       se,
                                             input logic [3:0] le);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            ADDR_STATUS:   r[3:0] = st;
            ADDR_MASK:     r[3:0] = mk;
            ADDR_CONTROL:  r[1:0] = {se, pe};
            ADDR_LAST_EVT: r[3:0] = le;
            default:       r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_mux

    // Reads answer on the data phase; zero-wait slave
    wire [31:0] next_hrdata = rd_take
        ? read_mux(haddr, status, mask, pri_per_en, sec_per_en, last_evt)
        : 32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= wr_take;
            wr_addr <= haddr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end else begin
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status <= STATUS_RESET;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= next_irq;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mask <= MASK_RESET;
        end else if (wr_mask) begin
            mask <= hwdata[3:0];
        end
    end

    // Response enables steer the master parity bits
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            {sec_per_en, pri_per_en} <= CTRL_RESET;
        end else if (wr_ctrl) begin
            pri_per_en <= hwdata[BIT_PRI_PER];
            sec_per_en <= hwdata[BIT_SEC_PER];
        end
    end

    // Last nonzero set pattern, for diagnosis
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            last_evt <= STATUS_RESET;
        end else if (|set_strobe) begin
            last_evt <= set_strobe;
        end
    end
endmodule : bpsl_status
`default_nettype wire

//--- verification/bpsl_status_assertions.sv
// Checker for the parity status outputs
`default_nettype none
module bpsl_chk
    import bpsl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic evt_valid,
    input wire logic [1:0] evt_type,
    input wire logic evt_upstream,
    input wire logic evt_on_secondary,
    input wire logic evt_parity_bad,
    input wire logic primary_parity_err_n,
    input wire logic secondary_parity_err_n,
    input wire logic pri_master,
    input wire logic sec_master,
    input wire logic pri_per_en,
    input wire logic sec_per_en,
    input wire logic [3:0] status,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic rd = evt_valid && evt_type == 2'h0;
    // Type 3 has odd parity zero, so it never counts as a write
    wire logic wr = evt_valid && ^evt_type;
    wire logic up = evt_upstream;
    wire logic sc = evt_on_secondary;
    wire logic bad = evt_parity_bad;
    wire logic pm = pri_master && pri_per_en && !sc && up && (rd || wr);
    wire logic sm = sec_master && sec_per_en && sc && !up && (rd || wr);
    wire logic [3:0] cause = {sm && (bad || !secondary_parity_err_n),
        pm && (bad || !primary_parity_err_n),
        bad && sc && (up ? wr : rd), bad && !sc && (up ? rd : wr)};
    sequence set2(int b);
        ##2 status[b];
    endsequence
    pri_det_a : assert property (cause[0] |-> set2(0))
        else $error("primary detected bit missed");
    sec_det_a : assert property (cause[1] |-> set2(1))
        else $error("secondary detected bit missed");
    pri_mdpe_a : assert property (cause[2] |-> set2(2))
        else $error("primary master bit missed");
    sec_mdpe_a : assert property (cause[3] |-> set2(3))
        else $error("secondary master bit missed");
    no_stray_a : assert property (
        (status & ~$past(status) & ~$past(cause, 2)) == 4'h0)
        else $error("status bit set without cause");
    pri_gate_a : assert property ($rose(status[2]) |->
        $past(pri_master, 2) && $past(pri_per_en, 2))
        else $error("primary master bit set while not allowed");
    sec_gate_a : assert property ($rose(status[3]) |->
        $past(sec_master, 2) && $past(sec_per_en, 2))
        else $error("secondary master bit set while not allowed");
    irq_idle_a : assert property (status == 4'h0 |-> !irq)
        else $error("interrupt with empty status");
endmodule : bpsl_chk
bind bpsl_status bpsl_chk chk_u (.clk_sys, .reset, .evt_valid, .evt_type,
    .evt_upstream, .evt_on_secondary, .evt_parity_bad, .primary_parity_err_n,
    .secondary_parity_err_n, .pri_master, .sec_master, .pri_per_en,
    .sec_per_en, .status, .irq);
`default_nettype wire

//--- verification/bpsl_pci_agent.sv
// Far-side bus agent that pulls the parity error pins
`default_nettype none
module bpsl_pci_agent (
    input  wire logic [1:0] perr_req,
    output logic            primary_parity_err_n,
    output logic            secondary_parity_err_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins are driven active low, so a released pin reads high
    assign primary_parity_err_n   = !perr_req[0];
    assign secondary_parity_err_n = !perr_req[1];
endmodule : bpsl_pci_agent
`default_nettype wire

//--- verification/bpsl_status_tb.sv
// Self-checking bench for the parity status block
`default_nettype none
module bpsl_status_tb
    import bpsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset, hsel, hwrite, evt_valid, evt_upstream, up, sc;
    logic evt_on_secondary, evt_parity_bad, pri_master, sec_master, bad, en;
    logic [7:0] haddr;
    logic [1:0] htrans, evt_type, perr_req;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [3:0] status, ex;
    logic hreadyout, hresp, pri_per_en, sec_per_en, irq;
    wire logic primary_parity_err_n, secondary_parity_err_n;
    int fail_count, n_checks, ty;
    bpsl_status dut_u (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .evt_valid, .evt_type, .evt_upstream, .evt_on_secondary,
        .evt_parity_bad, .primary_parity_err_n, .secondary_parity_err_n,
        .pri_master, .sec_master, .status, .pri_per_en, .sec_per_en, .irq);
    bpsl_pci_agent agent_u (.perr_req, .primary_parity_err_n,
        .secondary_parity_err_n);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Ready is judged just before the edge that samples it
    task automatic wait_rdy;
        int n;
        n = 0;
        @(negedge clk_sys);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 50) begin
            fail_count++;
            conclude();
        end
        rd = hrdata;
        @(posedge clk_sys);
    endtask : wait_rdy
    // A read compares its data with d
    task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr  <= a;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        chk(32'(hresp), 32'(HRESP_OKAY));
        if (!w) chk(rd, d);
    endtask : bus
    task automatic ev(input logic pin);
        evt_valid        <= 1'b1;
        evt_type         <= ty[1:0];
        evt_upstream     <= up;
        evt_on_secondary <= sc;
        evt_parity_bad   <= bad;
        perr_req         <= {pin && sc, pin && !sc};
        @(posedge clk_sys);
        evt_valid <= 1'b0;
        perr_req  <= 2'h0;
        repeat (2) @(posedge clk_sys);
    endtask : ev
    initial begin
        {hwrite, evt_valid, evt_upstream, evt_on_secondary} = 4'h0;
        {evt_parity_bad, pri_master, sec_master, htrans} = 5'h00;
        {haddr, hwdata, evt_type, perr_req} = 44'h000_0000_0000;
        {fail_count, n_checks, hsel, hsize, reset} = {64'h0, 5'h15};
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        bus(1'b0, ADDR_CONTROL, 32'(CTRL_RESET));
        bus(1'b0, 8'h10, 32'h0000_0000);
        $display("reset test done");
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, ADDR_CONTROL, (p == 0) ? 32'h0000_0000 : 32'h0000_0003);
            pri_master <= (p != 3);
            sec_master <= (p != 3);
            bad = (p != 1);
            en = (p == 1) || (p == 2);
            for (int i = 0; i < 16; i++) begin
                {up, sc, ty} = {i[1], i[0], i / 4};
                ev(p == 1);
                ex[0] = bad && !sc && (up ? ty == 0 : ty == 1 || ty == 2);
                ex[1] = bad && sc && (up ? ty == 1 || ty == 2 : ty == 0);
                ex[2] = en && !sc && up && ty != 3;
                ex[3] = en && sc && !up && ty != 3;
                bus(1'b0, ADDR_STATUS, 32'(ex));
                chk(rd, 32'(ex));
                bus(1'b1, ADDR_STATUS, 32'h0000_000F);
            end
            // Enables have long settled here, well after the control write
            chk(32'({sec_per_en, pri_per_en}),
                (p == 0) ? 32'h0000_0000 : 32'h0000_0003);
            $display("table pass %0d done", p);
        end
        bus(1'b1, ADDR_MASK, 32'h0000_0001);
        {ty, up, sc, bad} = {32'h0000_0000, 3'h5};
        ev(1'b0);
        bus(1'b1, ADDR_STATUS, 32'h0000_000E);
        bus(1'b0, ADDR_STATUS, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        bus(1'b0, ADDR_MASK, 32'h0000_0001);
        bus(1'b0, ADDR_LAST_EVT, 32'h0000_0001);
        bus(1'b1, ADDR_STATUS, 32'h0000_0001);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        $display("sticky test done");
        conclude();
    end
endmodule : bpsl_status_tb
`default_nettype wire
